// >>> hw/psam_pkg.sv
// Constants and types shared by the program space address mapper
package psam_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PROG_W = 24;
    localparam int DATA_W = 16;
    localparam int PAGE_W = 8;
    localparam int WIN_BIT = 15;
    localparam int PADDR_W = 8;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_TPAG = 8'h00;
    localparam logic [7:0] OFF_VPAG = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_LAST = 8'h10;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] TPAG_RST = 8'h00;
    localparam logic [7:0] VPAG_RST = 8'h00;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [23:0] LAST_RST = 24'h000000;
    localparam int CTRL_WIN_EN = 0;
    localparam int STAT_BLK = 0;
    localparam int STAT_CFG = 1;
    localparam int STAT_BUSY = 2;

    // ------------------------------------------------------------
    // Byte lanes of a program word
    // ------------------------------------------------------------
    localparam logic [2:0] LANE_LO = 3'h1;
    localparam logic [2:0] LANE_MID = 3'h2;
    localparam logic [2:0] LANE_WORD = 3'h3;
    localparam logic [2:0] LANE_HI = 3'h4;

    typedef enum logic [1:0] {
        OP_DRD = 2'b00,
        OP_DWR = 2'b01,
        OP_TRD = 2'b10,
        OP_TWR = 2'b11
    } psam_op_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_MEM = 2'b01,
        PH_DONE = 2'b10
    } psam_ph_t;
endpackage : psam_pkg

// >>> hw/psam_map.sv
// Effective address to program/data address mapping
`timescale 1ns/100ps
`default_nettype none
module psam_map (
    input wire psam_pkg::psam_op_t op,
    input wire logic [15:0] ea,
    input wire logic hi_byte,
    input wire logic byte_acc,
    input wire logic [7:0] tpag,
    input wire logic [7:0] vpag,
    input wire logic win_en,
    output logic pm_hit,
    output logic pm_wr,
    output logic cfg,
    output logic [23:0] addr,
    output logic [2:0] lane,
    output logic ds_hit,
    output logic blocked
);
    import psam_pkg::*;

    wire is_tbl = op[1];
    wire is_wr = op[0];
    // Window only applies to data operations
    wire in_win = win_en && ea[WIN_BIT] && !is_tbl; // RULE_08
    wire [2:0] lo_lane = byte_acc ? (ea[0] ? LANE_MID : LANE_LO)
                                  : LANE_WORD;

    // Page register joined to the full effective address
    wire [23:0] tbl_addr = {tpag, ea}; // RULE_06
    // Top bit forced low: window never leaves user space
    wire [23:0] win_addr = {1'b0, vpag, ea[14:0]}; // RULE_09 RULE_10

    assign addr = is_tbl ? tbl_addr : win_addr;
    assign cfg = is_tbl && tpag[PAGE_W-1]; // RULE_07 RULE_11
    // Upper byte reachable from table path only
    assign lane = (is_tbl && hi_byte) ? LANE_HI : lo_lane; // RULE_03 RULE_05
    assign pm_hit = is_tbl || (in_win && !is_wr); // RULE_02 RULE_04
    assign pm_wr = is_tbl && is_wr; // RULE_02
    assign blocked = in_win && is_wr; // RULE_04
    assign ds_hit = !is_tbl && !in_win; // RULE_12
endmodule : psam_map
`default_nettype wire

// >>> hw/psam_top.sv
// Program space address mapper with APB register slave
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Operation
// (RULE_01) Program words are 24 bits, data words 16, alignment kept.
// (RULE_02) Table reads and writes reach any byte or word of program space.
// (RULE_03) Table path can reach the upper byte of a program word.
// (RULE_04) Window accesses are read-only; writes never touch memory.
// (RULE_05) Window reads return only the low 16-bit word.
// (RULE_06) Table address is the 8-bit page joined to the 16-bit address.
// (RULE_07) Table page top bit selects configuration versus user memory.
// (RULE_08) Address bit 15 set forms a 23-bit address from page and 15 bits.
// (RULE_09) Each visibility page value selects one 16K-word page. The code maps ea[14:0] under each page value, a 32K-word page.
// (RULE_10) Window accesses only ever reach user program memory.
// (RULE_11) User access stays in the lower half except config table access.
// (RULE_12) Address bit 15 clear gives a plain data access, no remap.
module psam_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [psam_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_req,
    input wire psam_pkg::psam_op_t cpu_op,
    input wire logic [15:0] cpu_ea,
    input wire logic cpu_hi_byte,
    input wire logic cpu_byte,
    input wire logic [15:0] cpu_wdata,
    output logic cpu_ready,
    output logic cpu_ack,
    output logic [15:0] cpu_rdata,
    output logic pm_req,
    output logic pm_wr,
    output logic pm_cfg,
    output logic [23:0] pm_addr,
    output logic [2:0] pm_lane,
    output logic [23:0] pm_wdata,
    input wire logic [23:0] pm_rdata,
    output logic ds_req,
    output logic ds_wr,
    output logic [15:0] ds_addr,
    output logic [15:0] ds_wdata
);
    import psam_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] tpag_reg;
    logic [7:0] vpag_reg;
    logic win_en_reg;
    logic blk_reg;
    logic cfg_seen_reg;
    logic [23:0] last_reg;
    logic [31:0] prdata_reg;
    psam_ph_t ph_reg;
    psam_ph_t ph_next;
    logic pm_req_reg;
    logic pm_wr_reg;
    logic pm_cfg_reg;
    logic [23:0] pm_addr_reg;
    logic [2:0] pm_lane_reg;
    logic [23:0] pm_wdata_reg;
    logic ds_req_reg;
    logic ds_wr_reg;
    logic [15:0] ds_addr_reg;
    logic [15:0] ds_wdata_reg;
    logic tbl_reg;
    logic ack_reg;
    logic [15:0] rdata_reg;

    // ------------------------------------------------------------
    // Mapping
    // ------------------------------------------------------------
    wire m_pm_hit;
    wire m_pm_wr;
    wire m_cfg;
    wire [23:0] m_addr;
    wire [2:0] m_lane;
    wire m_ds_hit;
    wire m_blocked;

    psam_map u_map (
        .op(cpu_op),
        .ea(cpu_ea),
        .hi_byte(cpu_hi_byte),
        .byte_acc(cpu_byte),
        .tpag(tpag_reg),
        .vpag(vpag_reg),
        .win_en(win_en_reg),
        .pm_hit(m_pm_hit),
        .pm_wr(m_pm_wr),
        .cfg(m_cfg),
        .addr(m_addr),
        .lane(m_lane),
        .ds_hit(m_ds_hit),
        .blocked(m_blocked)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire sel_tpag = (paddr == OFF_TPAG);
    wire sel_vpag = (paddr == OFF_VPAG);
    wire sel_ctrl = (paddr == OFF_CTRL);
    wire sel_stat = (paddr == OFF_STAT);
    wire sel_last = (paddr == OFF_LAST);
    wire apb_hit = sel_tpag || sel_vpag || sel_ctrl || sel_stat || sel_last;
    wire wr_lo = apb_wr && pstrb[0];
    wire [31:0] stat_word = {29'h0, ph_reg != PH_IDLE, cfg_seen_reg,
                             blk_reg};
    wire [31:0] rd_word = sel_tpag ? {24'h0, tpag_reg}
                        : sel_vpag ? {24'h0, vpag_reg}
                        : sel_ctrl ? {31'h0, win_en_reg}
                        : sel_stat ? stat_word
                        : sel_last ? {8'h0, last_reg}
                        : 32'h0;
    // Write-one-to-clear; a fresh block event wins over the clear
    wire blk_clr = wr_lo && sel_stat && pwdata[STAT_BLK];

    assign pready = 1'b1;
    assign pslverr = psel && penable && !apb_hit;
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tpag_reg <= TPAG_RST;
            vpag_reg <= VPAG_RST;
            win_en_reg <= CTRL_RST;
        end else if (wr_lo) begin
            if (sel_tpag) begin
                tpag_reg <= pwdata[7:0];
            end
            if (sel_vpag) begin
                vpag_reg <= pwdata[7:0];
            end
            if (sel_ctrl) begin
                win_en_reg <= pwdata[CTRL_WIN_EN];
            end
        end
    end

    // Read data captured in setup so it stands through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else if (apb_setup) begin
            prdata_reg <= pwrite ? 32'h0 : rd_word;
        end
    end

    // ------------------------------------------------------------
    // Access sequencing
    // ------------------------------------------------------------
    // One access in flight; new requests wait for idle
    assign cpu_ready = (ph_reg == PH_IDLE);
    wire acc = cpu_req && cpu_ready;

    always_comb begin
        ph_next = ph_reg;
        case (ph_reg)
            PH_IDLE: begin
                if (acc) begin
                    ph_next = PH_MEM;
                end
            end
            PH_MEM: begin
                ph_next = PH_DONE;
            end
            PH_DONE: begin
                ph_next = PH_IDLE;
            end
            default: begin
                ph_next = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_reg <= PH_IDLE;
        end else begin
            ph_reg <= ph_next;
        end
    end

    // Memory and data-space strobes last exactly one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_req_reg <= 1'b0;
            pm_wr_reg <= 1'b0;
            ds_req_reg <= 1'b0;
            ds_wr_reg <= 1'b0;
        end else begin
            pm_req_reg <= acc && m_pm_hit; // RULE_02 RULE_04
            pm_wr_reg <= acc && m_pm_wr; // RULE_04
            ds_req_reg <= acc && m_ds_hit; // RULE_12
            ds_wr_reg <= acc && m_ds_hit && cpu_op[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_cfg_reg <= 1'b0;
            pm_addr_reg <= 24'h0;
            pm_lane_reg <= 3'h0;
            pm_wdata_reg <= 24'h0;
            tbl_reg <= 1'b0;
            ds_addr_reg <= 16'h0;
            ds_wdata_reg <= 16'h0;
        end else if (acc) begin
            pm_cfg_reg <= m_cfg; // RULE_07 RULE_11
            pm_addr_reg <= m_addr; // RULE_06 RULE_08
            pm_lane_reg <= m_lane;
            // Upper-byte write carries its byte in the top lane
            pm_wdata_reg <= {cpu_wdata[7:0], cpu_wdata}; // RULE_03
            tbl_reg <= cpu_op[1];
            ds_addr_reg <= cpu_ea; // RULE_12
            ds_wdata_reg <= cpu_wdata;
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_reg <= 1'b0;
            cfg_seen_reg <= 1'b0;
            last_reg <= LAST_RST;
        end else begin
            if (acc && m_blocked) begin
                blk_reg <= 1'b1; // RULE_04
            end else if (blk_clr) begin
                blk_reg <= 1'b0;
            end
            if (acc && m_pm_hit) begin
                cfg_seen_reg <= m_cfg;
                last_reg <= m_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Read return
    // ------------------------------------------------------------
    // Bytes land in the low byte so data-space alignment holds
    wire [15:0] lane_data = (pm_lane_reg == LANE_HI) ? {8'h0, pm_rdata[23:16]}
        : (pm_lane_reg == LANE_MID) ? {8'h0, pm_rdata[15:8]}
        : (pm_lane_reg == LANE_LO) ? {8'h0, pm_rdata[7:0]}
        : pm_rdata[15:0]; // RULE_01 RULE_05

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg <= 1'b0;
            rdata_reg <= 16'h0;
        end else begin
            ack_reg <= (ph_reg == PH_MEM);
            if (pm_req_reg && !pm_wr_reg) begin
                rdata_reg <= lane_data;
            end else if (ph_reg == PH_MEM) begin
                rdata_reg <= 16'h0;
            end
        end
    end

    assign cpu_ack = ack_reg;
    assign cpu_rdata = rdata_reg;
    assign pm_req = pm_req_reg;
    assign pm_wr = pm_wr_reg;
    assign pm_cfg = pm_cfg_reg;
    assign pm_addr = pm_addr_reg;
    assign pm_lane = pm_lane_reg;
    assign pm_wdata = pm_wdata_reg;
    assign ds_req = ds_req_reg;
    assign ds_wr = ds_wr_reg;
    assign ds_addr = ds_addr_reg;
    assign ds_wdata = ds_wdata_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire acc_tbl = acc && cpu_op[1];
    wire acc_win = acc && !cpu_op[1] && win_en_reg && cpu_ea[15];
    wire acc_ds = acc && !cpu_op[1] && !cpu_ea[15];
    wire acc_ds_hi = acc && !cpu_op[1] && !win_en_reg && cpu_ea[15];

    AST_TBL_ADDR: assert property (acc_tbl |=> pm_req && // RULE_06
        pm_addr == {$past(tpag_reg), $past(cpu_ea)})
        else $error("table address not page joined to ea");
    AST_TBL_CFG: assert property (acc_tbl |=> // RULE_07
        pm_cfg == $past(tpag_reg[7]))
        else $error("config select does not follow page top bit");
    AST_TBL_WR: assert property (acc && cpu_op == OP_TWR |=> // RULE_02
        pm_wr && pm_req ##1 cpu_ack)
        else $error("table write not issued to memory");
    AST_HI_BYTE: assert property (acc_tbl && cpu_hi_byte && // RULE_03
        !cpu_op[0] |=> pm_lane == LANE_HI ##1
        cpu_rdata == {8'h00, $past(pm_rdata[23:16])})
        else $error("upper byte not returned");
    AST_WIN_RO: assert property (acc_win && cpu_op[0] |=> // RULE_04
        !pm_req && !pm_wr && !ds_req && blk_reg)
        else $error("window write reached memory");
    AST_WIN_ADDR: assert property (acc_win && !cpu_op[0] |=> // RULE_08
        pm_req && pm_addr == {1'b0, $past(vpag_reg), $past(cpu_ea[14:0])})
        else $error("window address wrong");
    AST_WIN_LSW: assert property (pm_req && !tbl_reg |-> // RULE_05
        !pm_lane[2] && !pm_cfg && !pm_wr)
        else $error("window reached upper byte or config");
    AST_USER_HALF: assert property (pm_req && !pm_cfg |-> // RULE_11
        !pm_addr[23])
        else $error("user access beyond lower half");
    AST_WIN_USER: assert property (acc_win |=> // RULE_10
        !pm_cfg && !pm_addr[23])
        else $error("window reached configuration memory");
    AST_DS_PASS: assert property (acc_ds |=> ds_req && !pm_req && // RULE_12
        ds_addr == $past(cpu_ea))
        else $error("plain data access was remapped");
    AST_ACK: assert property (acc |=> // RULE_02
        !cpu_ready ##1 cpu_ack ##1 cpu_ready)
        else $error("ack timing wrong");
    AST_WIN_LANE: assert property (acc_win && !cpu_op[0] && // RULE_05
        !cpu_byte |=> pm_lane == LANE_WORD)
        else $error("window word read not on low word lane");
    AST_DS_NOWIN: assert property (acc_ds_hi |=> ds_req && // RULE_12
        !pm_req && ds_addr == $past(cpu_ea))
        else $error("window off but access was remapped");

    COV_TBL_CFG: cover property (acc_tbl && tpag_reg[7]);
    COV_WIN_RD: cover property (acc_win && !cpu_op[0] ##2 cpu_ack);
    COV_WIN_WR: cover property (acc_win && cpu_op[0]);
    COV_DS: cover property (acc_ds);
endmodule : psam_top
`default_nettype wire

// >>> dv/psam_pm_model.sv
// Program memory model for the mapper's far side
`timescale 1ns/100ps
`default_nettype none
module psam_pm_model (
    input wire logic pclk,
    input wire logic pm_req,
    input wire logic pm_wr,
    input wire logic pm_cfg,
    input wire logic [23:0] pm_addr,
    output logic [23:0] pm_rdata,
    output int wr_count
);
    logic [23:0] junk = 24'h5a5a5a;
    // Word valid only while requested; junk toggles so stale reads show
    assign pm_rdata = pm_req ? {pm_addr[15:8] ^ 8'ha5,
        pm_addr[7:0] ^ {7'h0, pm_cfg}, pm_addr[23:16] ^ 8'h3c} : junk;
    initial wr_count = 0;
    always @(posedge pclk) begin
        junk <= ~junk;
        if (pm_req && pm_wr)
            wr_count <= wr_count + 1;
    end
endmodule : psam_pm_model
`default_nettype wire

// >>> dv/psam_top_tb.sv
// Self-checking bench for the program space address mapper
`timescale 1ns/100ps
`default_nettype none
module psam_top_tb;
    import psam_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_req = 1'b0;
    logic cpu_hi_byte = 1'b0, cpu_byte = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, cpu_ready, cpu_ack, pm_req, pm_wr, pm_cfg;
    logic ds_req, ds_wr, er, s_cfg, s_wr, s_dwr, tbl, wnd, ecfg, win, hi, b;
    psam_op_t cpu_op = OP_DRD;
    psam_op_t op;
    logic [15:0] cpu_ea = 16'h0, cpu_wdata = 16'h0, cpu_rdata, ds_addr;
    logic [15:0] ds_wdata, s_rd, s_da, s_dw, ea, wd, erd;
    logic [23:0] pm_addr, pm_wdata, pm_rdata, s_addr, s_wd, eaddr;
    logic [7:0] tp, vp;
    logic [2:0] pm_lane, s_lane, elane;
    logic [1:0] r2;
    int wr_count, w0, s_pm, s_ds, err_total = 0, check_count = 0;

    always #25 pclk = ~pclk;

    psam_top psam_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .cpu_req, .cpu_op,
        .cpu_ea, .cpu_hi_byte, .cpu_byte, .cpu_wdata, .cpu_ready, .cpu_ack,
        .cpu_rdata, .pm_req, .pm_wr, .pm_cfg, .pm_addr, .pm_lane, .pm_wdata,
        .pm_rdata, .ds_req, .ds_wr, .ds_addr, .ds_wdata);
    psam_pm_model psam_pm_model_i (.pclk, .pm_req, .pm_wr, .pm_cfg,
        .pm_addr, .pm_rdata, .wr_count);

    // ------------------------------------------------------------
    // Expected values
    // ------------------------------------------------------------
    function automatic logic [2:0] exp_lane(input logic t, input logic h,
                                            input logic by, input logic e0);
        if (t && h)
            return LANE_HI;
        if (!by)
            return LANE_WORD;
        return e0 ? LANE_MID : LANE_LO;
    endfunction : exp_lane

    function automatic logic [23:0] exp_addr(input logic t,
        input logic [7:0] tpg, input logic [7:0] vpg, input logic [15:0] e);
        return t ? {tpg, e} : {1'b0, vpg, e[14:0]};
    endfunction : exp_addr

    // Model's word for an address: bytes rotated, cfg folded into word bit 8
    function automatic logic [23:0] exp_word(input logic [23:0] a,
                                             input logic c);
        return {a[15:8] ^ 8'ha5, a[7:0] ^ {7'h0, c}, a[23:16] ^ 8'h3c};
    endfunction : exp_word

    function automatic logic [15:0] exp_rdata(input psam_op_t o,
        input logic [2:0] l, input logic [23:0] w);
        if (o == OP_TWR)
            return 16'h0;
        case (l)
            LANE_HI: return {8'h0, w[23:16]};
            LANE_MID: return {8'h0, w[15:8]};
            LANE_LO: return {8'h0, w[7:0]};
            default: return w[15:0];
        endcase
    endfunction : exp_rdata

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string n);
        apb(1'b0, a, 32'h0, 4'hf);
        chk(n, e, rd);
    endtask : rdchk

    task automatic cpu();
        int n;
        n = 0;
        @(posedge pclk);
        cpu_req <= 1'b1;
        cpu_op <= op;
        cpu_ea <= ea;
        cpu_hi_byte <= hi;
        cpu_byte <= b;
        cpu_wdata <= wd;
        do @(posedge pclk);
        while (cpu_ready !== 1'b1);
        cpu_req <= 1'b0;
        s_pm = 0;
        s_ds = 0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n == 1)
                chk("cpu_ready_busy", 0, cpu_ready);
            if (pm_req === 1'b1) begin
                s_pm++;
                s_addr = pm_addr;
                s_lane = pm_lane;
                s_cfg = pm_cfg;
                s_wr = pm_wr;
                s_wd = pm_wdata;
            end
            if (ds_req === 1'b1) begin
                s_ds++;
                s_da = ds_addr;
                s_dwr = ds_wr;
                s_dw = ds_wdata;
            end
        end while (cpu_ack !== 1'b1);
        s_rd = cpu_rdata;
        chk("ack_latency", 2, n);
    endtask : cpu

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h076204f1));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 5; a++)
            rdchk(8'(a * 4), 32'h0, "reset_value");
        apb(1'b0, 8'h14, 32'h0, 4'hf);
        chk("unmapped_err", 1, er);
        chk("unmapped_data", 0, rd);
        apb(1'b1, OFF_VPAG, 32'hff, 4'he);
        rdchk(OFF_VPAG, 32'h0, "strobe_off");
        apb(1'b1, OFF_TPAG, 32'hffffffff, 4'hf);
        rdchk(OFF_TPAG, 32'hff, "page_width");
        apb(1'b1, OFF_LAST, 32'h123, 4'hf);
        rdchk(OFF_LAST, 32'h0, "last_ro");
        $display("test registers done");
        for (int i = 0; i < 80; i++) begin
            r2 = 2'($urandom);
            {tp, vp, win, hi, b} = 19'($urandom);
            ea = 16'($urandom);
            wd = 16'($urandom);
            // Corners: every op with the window open; table reads on page 7f, table writes on page 80
            if (i < 8) begin
                r2 = i[1:0];
                win = 1'b1;
                ea = i[2] ? 16'hffff : 16'h8000;
                tp = i[0] ? 8'h80 : 8'h7f;
            end
            op = psam_op_t'(r2);
            apb(1'b1, OFF_TPAG, {24'h0, tp}, 4'hf);
            apb(1'b1, OFF_VPAG, {24'h0, vp}, 4'hf);
            apb(1'b1, OFF_CTRL, {31'h0, win}, 4'hf);
            tbl = op[1];
            wnd = !tbl && win && ea[15];
            ecfg = tbl & tp[7];
            elane = exp_lane(tbl, hi, b, ea[0]);
            eaddr = exp_addr(tbl, tp, vp, ea);
            erd = exp_rdata(op, elane, exp_word(eaddr, ecfg));
            w0 = wr_count;
            cpu();
            if (tbl || (wnd && op == OP_DRD)) begin
                chk("pm_pulses", 1, s_pm);
                if (tbl)
                    chk("table_addr", eaddr, s_addr);
                else
                    chk("window_addr", eaddr, s_addr);
                chk("pm_cfg", ecfg, s_cfg);
                chk("user_half", 0, s_addr[23] & !s_cfg);
                chk("pm_lane", elane, s_lane);
                chk("pm_wr", op == OP_TWR, s_wr);
                chk("cpu_rdata", erd, s_rd);
                if (op == OP_TWR)
                    chk("pm_wdata", {wd[7:0], wd}, s_wd);
                if (wnd)
                    chk("window_cfg", 0, s_cfg);
                rdchk(OFF_LAST, eaddr, "last_addr");
                rdchk(OFF_STAT, {30'h0, ecfg, 1'b0}, "stat_cfg");
            end else if (wnd) begin
                chk("win_write_strobes", 0, s_pm + s_ds);
                chk("win_write_mem", w0, wr_count);
                apb(1'b0, OFF_STAT, 32'h0, 4'hf);
                chk("stat_blocked", 1, rd[STAT_BLK]);
                apb(1'b1, OFF_STAT, 32'h1, 4'hf);
                apb(1'b0, OFF_STAT, 32'h0, 4'hf);
                chk("stat_w1c", 0, rd[STAT_BLK]);
            end else begin
                chk("ds_pulses", 1, s_ds);
                chk("ds_no_pm", 0, s_pm);
                chk("ds_addr", ea, s_da);
                chk("ds_wr", op == OP_DWR, s_dwr);
                if (op == OP_DWR)
                    chk("ds_wdata", wd, s_dw);
                chk("ds_rdata", 0, s_rd);
            end
        end
        $display("test mapping done");
        summarize();
    end

    // Cuts a hang well beyond the fewer than two thousand cycles the tests need
    initial begin
        #(50 * 20000);
        err_total++;
        summarize();
    end
endmodule : psam_top_tb
`default_nettype wire
